// file: atgc_top.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

`include "atgc_consts.svh"

module atgc_top (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // avalon-mm slave
  input  wire logic [7:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  // flag and status sources
  input  wire logic                   i_int_n,
  input  wire logic                   i_validity,
  input  wire logic                   i_user,
  input  wire logic                   i_chan_status,
  input  wire logic                   i_transmission_error,
  input  wire logic                   i_subframe_clock,
  input  wire logic                   i_block_start_flag,
  input  wire logic                   i_unlock,
  input  wire logic                   i_non_audio,
  input  wire logic                   i_chan_status_updated,
  input  wire logic                   i_emphasis_flag,
  input  wire logic                   i_copy_flag_low,
  input  wire logic                   i_zero_data_flag,
  // transmit bit clock before inversion
  input  wire logic                   i_tx_bitclk,
  // general purpose output pins
  output logic                        o_pin1,
  output logic                        o_pin2,
  // transmit interface format
  output atgc_pkg::atgc_fmt_type      o_tx_frame_format,
  output atgc_pkg::atgc_wl_type       o_tx_word_length,
  output logic [4:0]                  o_tx_word_bits,
  output logic                        o_tx_bitclk_invert,
  output logic                        o_tx_lrclk_polarity,
  output logic                        o_tx_lrclk_invert,
  output logic                        o_tx_dsp_mode_b,
  output logic                        o_tx_bitclk,
  // interrupt
  output logic                        o_irq
);

  import atgc_pkg::*;

  // ----------------------------------------------------------
  // register state
  // ----------------------------------------------------------
  logic [3:0]                 pin1_source_sel_q;
  logic [3:0]                 pin2_source_sel_q;
  atgc_fmt_type               tx_frame_format_q;
  atgc_wl_type                tx_word_length_q;
  logic                       tx_bitclk_invert_q;
  logic                       tx_lrclk_polarity_q;
  logic [`ATGC_IRQ_WIDTH-1:0] irq_stat_q;
  logic [`ATGC_IRQ_WIDTH-1:0] irq_mask_q;

  // ----------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------
  atgc_bus_type               bus_q;
  atgc_bus_type               bus_d;
  logic                       req;
  logic                       take;
  logic                       wr_take;
  logic                       wr_lane0;

  // ----------------------------------------------------------
  // address decode
  // ----------------------------------------------------------
  logic                       hit_pin1;
  logic                       hit_pin2;
  logic                       hit_txfmt;
  logic                       hit_stat;
  logic                       hit_mask;
  logic [7:0]                 wdata;
  logic [7:0]                 rd_byte;
  logic [31:0]                readdata_d;

  // ----------------------------------------------------------
  // pin routing and events
  // ----------------------------------------------------------
  logic [15:0]                flag_vec;
  logic                       int_n;
  logic                       pin1_rise;
  logic                       pin2_rise;
  logic [`ATGC_IRQ_WIDTH-1:0] events;
  logic [`ATGC_IRQ_WIDTH-1:0] clr_mask;

  // ----------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ----------------------------------------------------------

  // a request is held by the master until waitrequest drops
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & (bus_q == BUS_IDLE);
  assign take              = req & (bus_q == BUS_ACK);
  assign wr_take           = take & i_avs_write;
  assign wr_lane0          = wr_take & i_avs_byteenable[0];
  assign wdata             = i_avs_writedata[7:0];

  // next answer state
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // answer state register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // ----------------------------------------------------------
  // address decode (word aligned, index times four)
  // ----------------------------------------------------------

  // low address bits must be zero; anything else is unmapped
  assign hit_pin1  = i_avs_address == {`ATGC_IDX_PIN1, 2'b00};
  assign hit_pin2  = i_avs_address == {`ATGC_IDX_PIN2, 2'b00};
  assign hit_txfmt = i_avs_address == {`ATGC_IDX_TXFMT, 2'b00};
  assign hit_stat  = i_avs_address == {`ATGC_IDX_IRQ_STAT, 2'b00};
  assign hit_mask  = i_avs_address == {`ATGC_IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------

  // first pin source, low nibble of its register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin1_source_sel_q <= `ATGC_PIN1_RST;
    end else if (wr_lane0 && hit_pin1) begin
      pin1_source_sel_q <= wdata[`ATGC_PIN1_LSB +: 4];
    end
  end

  // second pin source, high nibble of its register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin2_source_sel_q <= `ATGC_PIN2_RST;
    end else if (wr_lane0 && hit_pin2) begin
      pin2_source_sel_q <= wdata[`ATGC_PIN2_LSB +: 4];
    end
  end

  // transmit format fields; all codes are legal, none refused
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tx_frame_format_q   <= atgc_fmt_type'(`ATGC_FMT_RST);
      tx_word_length_q    <= atgc_wl_type'(`ATGC_WL_RST);
      tx_bitclk_invert_q  <= 1'b0;
      tx_lrclk_polarity_q <= 1'b0;
    end else if (wr_lane0 && hit_txfmt) begin
      tx_frame_format_q   <= atgc_fmt_type'(wdata[`ATGC_FMT_LSB +: 2]);
      tx_word_length_q    <= atgc_wl_type'(wdata[`ATGC_WL_LSB +: 2]);
      tx_bitclk_invert_q  <= wdata[`ATGC_BCP_BIT];
      tx_lrclk_polarity_q <= wdata[`ATGC_LRP_BIT];
    end
  end

  // ----------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------

  // bit 0 pin1 rise, bit 1 pin2 rise, bit 2 format rewritten
  assign events   = {wr_lane0 & hit_txfmt, pin2_rise, pin1_rise};
  assign clr_mask = (wr_lane0 && hit_stat) ?
                    wdata[`ATGC_IRQ_WIDTH-1:0] : '0;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_mask) | events;
    end
  end

  // mask, same layout as status
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_mask_q <= '0;
    end else if (wr_lane0 && hit_mask) begin
      irq_mask_q <= wdata[`ATGC_IRQ_WIDTH-1:0];
    end
  end

  // level interrupt, registered so it is glitch free
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((irq_stat_q & ~clr_mask | events) & irq_mask_q);
    end
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------

  // reserved bits and unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_pin1) begin
      rd_byte[`ATGC_PIN1_LSB +: 4] = pin1_source_sel_q;
    end else if (hit_pin2) begin
      rd_byte[`ATGC_PIN2_LSB +: 4] = pin2_source_sel_q;
    end else if (hit_txfmt) begin
      rd_byte[`ATGC_FMT_LSB +: 2] = tx_frame_format_q;
      rd_byte[`ATGC_WL_LSB +: 2]  = tx_word_length_q;
      rd_byte[`ATGC_BCP_BIT]      = tx_bitclk_invert_q;
      rd_byte[`ATGC_LRP_BIT]      = tx_lrclk_polarity_q;
    end else if (hit_stat) begin
      rd_byte[`ATGC_IRQ_WIDTH-1:0] = irq_stat_q;
    end else if (hit_mask) begin
      rd_byte[`ATGC_IRQ_WIDTH-1:0] = irq_mask_q;
    end
    readdata_d = {24'h000000, rd_byte};
  end

  // sampled in the wait cycle, stands through the answer edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && bus_q == BUS_IDLE) begin
      o_avs_readdata <= readdata_d;
    end
  end

  // ----------------------------------------------------------
  // output pin routing
  // ----------------------------------------------------------

  // own interrupt folds into the shared active-low line
  assign int_n = i_int_n & ~o_irq;

  // vector index equals the select code; top three tied low
  assign flag_vec = {
    3'b000,
    i_zero_data_flag,
    i_copy_flag_low,
    i_emphasis_flag,
    i_chan_status_updated,
    i_non_audio,
    i_unlock,
    i_block_start_flag,
    i_subframe_clock,
    i_transmission_error,
    i_chan_status,
    i_user,
    i_validity,
    int_n
  };

  // first pin
  atgc_pin_mux u_pin1 (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_sel   (pin1_source_sel_q),
    .i_flags (flag_vec),
    .o_pin   (o_pin1),
    .o_rise  (pin1_rise)
  );

  // second pin
  atgc_pin_mux u_pin2 (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_sel   (pin2_source_sel_q),
    .i_flags (flag_vec),
    .o_pin   (o_pin2),
    .o_rise  (pin2_rise)
  );

  // ----------------------------------------------------------
  // transmit format outputs
  // ----------------------------------------------------------

  // raw fields straight from the registers
  assign o_tx_frame_format   = tx_frame_format_q;
  assign o_tx_word_length    = tx_word_length_q;
  assign o_tx_bitclk_invert  = tx_bitclk_invert_q;
  assign o_tx_lrclk_polarity = tx_lrclk_polarity_q;

  // both top codes mean 24 bits
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_tx_word_bits <= 5'd20;
    end else begin
      unique case (tx_word_length_q)
        WL_16:  o_tx_word_bits <= 5'd16;
        WL_20:  o_tx_word_bits <= 5'd20;
        WL_24A: o_tx_word_bits <= 5'd24;
        WL_24B: o_tx_word_bits <= 5'd24;
      endcase
    end
  end

  // one bit, two meanings: polarity outside dsp, sub-mode inside
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_tx_lrclk_invert <= 1'b0;
      o_tx_dsp_mode_b   <= 1'b0;
    end else begin
      o_tx_lrclk_invert <= tx_lrclk_polarity_q &
                           (tx_frame_format_q != FMT_DSP);
      o_tx_dsp_mode_b   <= tx_lrclk_polarity_q &
                           (tx_frame_format_q == FMT_DSP);
    end
  end

  // same inversion whether the bit clock is made or received;
  // costs one cycle of delay on the resampled clock
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_tx_bitclk <= 1'b0;
    end else begin
      o_tx_bitclk <= i_tx_bitclk ^ tx_bitclk_invert_q;
    end
  end

endmodule

`default_nettype wire

// file: atgc_consts.svh
`ifndef ATGC_CONSTS_SVH
`define ATGC_CONSTS_SVH

// ------------------------------------------------------------
// register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define ATGC_IDX_PIN1      6'h18
`define ATGC_IDX_PIN2      6'h1a
`define ATGC_IDX_TXFMT     6'h1b
`define ATGC_IDX_IRQ_STAT  6'h1c
`define ATGC_IDX_IRQ_MASK  6'h1d

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ATGC_PIN1_LSB      0
`define ATGC_PIN2_LSB      4
`define ATGC_FMT_LSB       0
`define ATGC_WL_LSB        2
`define ATGC_BCP_BIT       4
`define ATGC_LRP_BIT       5

// ------------------------------------------------------------
// reset values and the interrupt register width
// ------------------------------------------------------------
`define ATGC_PIN1_RST      4'h7
`define ATGC_PIN2_RST      4'h4
`define ATGC_FMT_RST       2'h2
`define ATGC_WL_RST        2'h1
`define ATGC_IRQ_WIDTH     3

`endif

// file: atgc_pkg.sv
package atgc_pkg;

  // transmit frame format codes
  typedef enum logic [1:0] {
    FMT_RIGHT = 2'h0,
    FMT_LEFT  = 2'h1,
    FMT_I2S   = 2'h2,
    FMT_DSP   = 2'h3
  } atgc_fmt_type;

  // transmit word length codes
  typedef enum logic [1:0] {
    WL_16  = 2'h0,
    WL_20  = 2'h1,
    WL_24A = 2'h2,
    WL_24B = 2'h3
  } atgc_wl_type;

  // output pin source codes
  typedef enum logic [3:0] {
    SRC_INT_N     = 4'h0,
    SRC_VALIDITY  = 4'h1,
    SRC_USER      = 4'h2,
    SRC_CHAN_STAT = 4'h3,
    SRC_TRANSMISSION_ERROR = 4'h4,
    SRC_SUBFRAME  = 4'h5,
    SRC_BLOCK     = 4'h6,
    SRC_UNLOCK    = 4'h7,
    SRC_NON_AUDIO = 4'h8,
    SRC_CS_UPD    = 4'h9,
    SRC_EMPHASIS  = 4'ha,
    SRC_COPY_LOW  = 4'hb,
    SRC_ZERO_DATA = 4'hc
  } atgc_src_type;

  // bus answer state, gray along idle -> answer
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } atgc_bus_type;

endpackage

// file: atgc_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none

module atgc_pin_mux (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // selection and sources
  input  wire logic [3:0]  i_sel,
  input  wire logic [15:0] i_flags,
  // pin and event
  output logic             o_pin,
  output logic             o_rise
);

  logic pin_d;

  // codes above the last source fall on tied-low vector bits
  always_comb begin
    pin_d = i_flags[i_sel];
  end

  // registered pin so the selection never glitches the output
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= pin_d;
    end
  end

  // rising edge of the routed signal, one-cycle pulse
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rise <= 1'b0;
    end else begin
      o_rise <= pin_d & ~o_pin;
    end
  end

endmodule

`default_nettype wire

// file: atgc_top_props.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// port-level checks on the transmit format and register bus
// ------------------------------------------------------------
module atgc_top_props
  import atgc_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // avalon-mm slave
  input  wire logic [7:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  input  wire logic [31:0]            o_avs_readdata,
  input  wire logic                   o_avs_waitrequest,
  // transmit interface format
  input  wire logic                   i_tx_bitclk,
  input  wire atgc_pkg::atgc_fmt_type o_tx_frame_format,
  input  wire atgc_pkg::atgc_wl_type  o_tx_word_length,
  input  wire logic [4:0]             o_tx_word_bits,
  input  wire logic                   o_tx_bitclk_invert,
  input  wire logic                   o_tx_lrclk_polarity,
  input  wire logic                   o_tx_lrclk_invert,
  input  wire logic                   o_tx_dsp_mode_b,
  input  wire logic                   o_tx_bitclk
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // first edge out of reset sees the documented defaults
  chk_reset_fields: assert property (
    !$past(i_nrst) |-> o_tx_frame_format == FMT_I2S &&
      o_tx_word_length == WL_20 && !o_tx_bitclk_invert &&
      !o_tx_lrclk_polarity)
    else $error("format fields wrong after reset");
  chk_word_bits: assert property (
    $past(i_nrst) |-> o_tx_word_bits ==
      ($past(o_tx_word_length) == WL_16 ? 5'h10 :
       $past(o_tx_word_length) == WL_20 ? 5'h14 : 5'h18))
    else $error("word bits do not follow length field");
  chk_bitclk_xor: assert property (
    $past(i_nrst) |->
      o_tx_bitclk == ($past(i_tx_bitclk) ^ $past(o_tx_bitclk_invert)))
    else $error("bit clock inversion wrong");
  chk_lrclk_inv: assert property (
    $past(i_nrst) |-> o_tx_lrclk_invert ==
      ($past(o_tx_lrclk_polarity) && $past(o_tx_frame_format) != FMT_DSP))
    else $error("lr clock inversion wrong");
  chk_dsp_sub_mode: assert property (
    $past(i_nrst) |-> o_tx_dsp_mode_b ==
      ($past(o_tx_lrclk_polarity) && $past(o_tx_frame_format) == FMT_DSP))
    else $error("dsp sub mode wrong");
  // exactly one wait cycle per request
  chk_one_wait: assert property (
    $rose(i_avs_read || i_avs_write) |->
      o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("wait cycle count wrong");
  chk_fmt_write: assert property (
    i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h6c &&
      i_avs_byteenable[0] |=>
      o_tx_frame_format == $past(i_avs_writedata[1:0]))
    else $error("format write not taken");
  chk_fmt_read: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h6c |->
      o_avs_readdata[5:0] == {o_tx_lrclk_polarity, o_tx_bitclk_invert,
      o_tx_word_length, o_tx_frame_format})
    else $error("format readback differs from outputs");
endmodule

bind atgc_top atgc_top_props atgc_top_props_i (
  .i_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
  .o_avs_waitrequest, .i_tx_bitclk, .o_tx_frame_format,
  .o_tx_word_length, .o_tx_word_bits, .o_tx_bitclk_invert,
  .o_tx_lrclk_polarity, .o_tx_lrclk_invert, .o_tx_dsp_mode_b,
  .o_tx_bitclk
);

`default_nettype wire

// file: atgc_audio_peer.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// far-side audio processor: raw transmit bit clock
// ------------------------------------------------------------
module atgc_audio_peer (
  // clock and control
  input  wire logic i_clk,
  input  wire logic i_run,
  // raw bit clock
  output logic      o_bclk
);
  // parked low while i_run is low, so a stale level never passes as data
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      o_bclk <= 1'h0;
    end else begin
      o_bclk <= ~o_bclk;
    end
  end
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module tb;
  import atgc_pkg::*;
  typedef struct {logic [3:0] code; logic [12:0] pat; logic exp;}
    atgc_row_type;
  logic         i_clk, i_nrst, rd, wr, wreq, run, bclk, irq;
  logic         pin1, pin2, inv, pol, lrinv, dspb, tbclk;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, got;
  logic [3:0]   be;
  logic [12:0]  src;
  logic [4:0]   wbits;
  atgc_fmt_type fmt;
  atgc_wl_type  wl;
  atgc_row_type rows[16];
  int           fails = 0;
  int           comparisons = 0;
  int           cyc = 0;

  atgc_top atgc_top_i (
    .i_clk, .i_nrst, .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_int_n(src[0]),
    .i_validity(src[1]), .i_user(src[2]), .i_chan_status(src[3]),
    .i_transmission_error(src[4]), .i_subframe_clock(src[5]),
    .i_block_start_flag(src[6]), .i_unlock(src[7]),
    .i_non_audio(src[8]), .i_chan_status_updated(src[9]),
    .i_emphasis_flag(src[10]), .i_copy_flag_low(src[11]),
    .i_zero_data_flag(src[12]), .i_tx_bitclk(bclk), .o_pin1(pin1),
    .o_pin2(pin2), .o_tx_frame_format(fmt), .o_tx_word_length(wl),
    .o_tx_word_bits(wbits), .o_tx_bitclk_invert(inv),
    .o_tx_lrclk_polarity(pol), .o_tx_lrclk_invert(lrinv),
    .o_tx_dsp_mode_b(dspb), .o_tx_bitclk(tbclk), .o_irq(irq)
  );
  atgc_audio_peer atgc_audio_peer_i (.i_clk, .i_run(run), .o_bclk(bclk));

  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one bus cycle; waitrequest and read data taken at the same edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    be <= b;
    do begin
      @(posedge i_clk);
    end while (wreq);
    got = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  function automatic logic [4:0] bits_of(input logic [1:0] w);
    return w == 2'h0 ? 5'h10 : w == 2'h1 ? 5'h14 : 5'h18;
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, ample for about 580 cycles of tests
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish;
    end
  end

  initial begin
    i_nrst = 1'h0;
    {rd, wr, run, adr, wdat, be, src} = '0;
    for (int c = 0; c < 16; c++) begin
      rows[c] = '{c[3:0], (c < 13) ? 13'h1 << c : 13'h0, c < 13};
    end
    tick(12);
    i_nrst <= 1'h1;
    run <= 1'h1;
    bus(0, 8'h60, 32'h0, 4'h1);
    chk("pin1 select", 32'h7, got);
    bus(0, 8'h6c, 32'h0, 4'h1);
    chk("format reg", 32'h6, got);
    chk("word bits", 32'h14, wbits);
    // every select code, its source lit (none for codes 13 to 15) then all others lit
    foreach (rows[r]) begin
      bus(1, 8'h60, {28'h0, rows[r].code}, 4'h1);
      bus(1, 8'h68, {24'h0, rows[r].code, 4'h0}, 4'h1);
      src <= rows[r].pat;
      tick(3);
      chk("pin1", rows[r].exp, pin1);
      chk("pin2", rows[r].exp, pin2);
      src <= ~rows[r].pat;
      tick(3);
      chk("pin1 others", 32'h0, pin1);
    end
    // all format codes, lengths, inversions and sub modes
    for (int v = 0; v < 64; v++) begin
      bus(1, 8'h6c, v, 4'h1);
      tick(2);
      chk("format", v[1:0], fmt);
      chk("word length", v[3:2], wl);
      // bit clock toggles every edge, so last sample is the inverse
      chk("bitclk out", bclk == v[4], tbclk);
      chk("word bits", bits_of(v[3:2]), wbits);
      chk("bitclk invert", v[4], inv);
      chk("lrclk invert", v[5] && v[1:0] != 2'h3, lrinv);
      chk("dsp mode b", v[5] && v[1:0] == 2'h3, dspb);
    end
    bus(1, 8'h6c, 32'h2, 4'he);
    bus(0, 8'h6c, 32'h0, 4'h1);
    chk("lane off write", 32'h3f, got);
    bus(0, 8'h64, 32'h0, 4'h1);
    chk("unmapped read", 32'h0, got);
    // interrupt: unmask format event, raise, join pin, clear, mask
    bus(1, 8'h74, 32'h4, 4'h1);
    bus(1, 8'h70, 32'h7, 4'h1);
    bus(1, 8'h6c, 32'h6, 4'h1);
    bus(1, 8'h60, 32'h0, 4'h1);
    src <= 13'h1;
    tick(3);
    chk("irq raised", 32'h1, irq);
    chk("pin1 irq joined", 32'h0, pin1);
    bus(0, 8'h70, 32'h0, 4'h1);
    chk("irq status", 32'h4, got);
    bus(1, 8'h70, 32'h4, 4'h1);
    tick(3);
    chk("irq cleared", 32'h0, irq);
    chk("pin1 int", 32'h1, pin1);
    bus(1, 8'h74, 32'h0, 4'h1);
    bus(1, 8'h6c, 32'h3, 4'h1);
    tick(3);
    chk("irq masked", 32'h0, irq);
    // second reset in mid-run restores defaults
    i_nrst <= 1'h0;
    tick(2);
    i_nrst <= 1'h1;
    tick(2);
    chk("format after reset", FMT_I2S, fmt);
    chk("bits after reset", 32'h14, wbits);
    chk("polarity after reset", 32'h0, pol);
    tally_and_finish;
  end
endmodule

`default_nettype wire
